// ---- hw/led_channel_pwm_shutdown_ctrl.sv ----
// LED controller top: serial slave, registers, shutdown and outputs
`timescale 1ns/1ps
module led_channel_pwm_shutdown_ctrl import led_pkg::*; #(
  parameter logic [6:0] DEV_ADDR     = 7'h34, // arbitrary value
  parameter int         SWEEP_CYCLES = SPREAD_HALF_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  ce,
  // Serial bus pins
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  // Shutdown pin
  input  wire logic                  hw_shutdown_n_pin,
  // Fault sensing from the output stage
  input  wire logic [17:0]           short_sense,
  input  wire logic [17:0]           open_sense,
  // Output stage
  output logic [17:0]                led_output_n,
  output logic [17:0][15:0]          current_scale,
  output logic [7:0]                 global_current_level
);

  logic [1:0]  rst_sy_q;
  logic        rst_n;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      rst_sy_q <= 2'b00;
    else
      rst_sy_q <= {rst_sy_q[0], 1'b1};
  end
  assign rst_n = rst_sy_q[1];

  // Pin synchronisers: sdb, scl, sda, short, open
  logic [38:0] pin_raw, pin_lvl_q, pin_lvl_d;
  logic [2:0][38:0] pin_sy_q;
  logic        sdb_q, scl_q, sda_q, sdb_d, scl_d, sda_d;
  logic        sdb_rise, scl_rise, scl_fall, start_cond, stop_cond;

  assign pin_raw = {hw_shutdown_n_pin, scl_in, sda_in, short_sense,
                    open_sense};

  always_comb begin
    for (int i = 0; i < 39; i++)
      pin_lvl_d[i] = (pin_sy_q[1][i] == pin_sy_q[2][i]) ?
                     pin_sy_q[2][i] : pin_lvl_q[i];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sy_q  <= {3{PIN_RESET}};
      pin_lvl_q <= PIN_RESET;
    end else if (ce) begin
      pin_sy_q  <= {pin_sy_q[1], pin_sy_q[0], pin_raw};
      pin_lvl_q <= pin_lvl_d;
    end
  end

  assign {sdb_q, scl_q, sda_q} = pin_lvl_q[38:36];
  assign {sdb_d, scl_d, sda_d} = pin_lvl_d[38:36];
  assign sdb_rise   = sdb_d && !sdb_q;
  assign scl_rise   = scl_d && !scl_q;
  assign scl_fall   = !scl_d && scl_q;
  assign start_cond = scl_q && scl_d && sda_q && !sda_d;
  assign stop_cond  = scl_q && scl_d && !sda_q && sda_d;

  // Register storage and read path
  logic [7:0]  mem_q [0:127];
  logic [4:0][7:0] status_q, status_d;
  logic [17:0][15:0] duty_q, duty_d;
  logic [6:0]  ptr_q, ptr_d;
  logic [7:0]  rd_data;

  always_comb begin
    rd_data = mem_q[ptr_q];
    if (ptr_q >= ADDR_STATUS_FIRST && ptr_q <= ADDR_STATUS_LAST)
      rd_data = status_q[3'(ptr_q - ADDR_STATUS_FIRST)];
    else if (ptr_q == ADDR_UPDATE || ptr_q == ADDR_RESET)
      rd_data = 8'h00;
  end

  // Serial slave
  i2c_state_type state_q, state_d;
  logic [2:0]  cnt_q, cnt_d;
  logic [7:0]  shift_q, shift_d;
  logic        rw_q, rw_d, full_q, full_d, oe_q, oe_d;
  logic        wr_en;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    shift_d = shift_q;
    ptr_d   = ptr_q;
    rw_d    = rw_q;
    full_d  = full_q;
    oe_d    = oe_q;
    wr_en   = 1'b0;
    if (sdb_rise) begin
      state_d = ST_IDLE;
      oe_d    = 1'b0;
      full_d  = 1'b0;
    end else if (start_cond) begin
      state_d = ST_ADDR;
      cnt_d   = 3'h0;
      full_d  = 1'b0;
      oe_d    = 1'b0;
    end else if (stop_cond) begin
      state_d = ST_IDLE;
      oe_d    = 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
        end
        ST_ADDR, ST_REG, ST_WR: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_d};
            cnt_d   = cnt_q + 3'h1;
            full_d  = cnt_q == 3'h7;
          end else if (scl_fall && full_q) begin
            full_d = 1'b0;
            oe_d   = 1'b1;
            if (state_q == ST_ADDR) begin
              rw_d    = shift_q[0];
              state_d = ST_ACK_ADDR;
              if (shift_q[7:1] != DEV_ADDR) begin
                state_d = ST_IDLE;
                oe_d    = 1'b0;
              end
            end else if (state_q == ST_REG) begin
              ptr_d   = shift_q[6:0];
              state_d = ST_ACK_REG;
            end else begin
              wr_en   = 1'b1;
              ptr_d   = ptr_q + 7'h01;
              state_d = ST_ACK_WR;
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_REG, ST_ACK_WR: begin
          if (scl_fall) begin
            cnt_d = 3'h0;
            if (state_q == ST_ACK_ADDR && rw_q) begin
              shift_d = rd_data;
              ptr_d   = ptr_q + 7'h01;
              oe_d    = !rd_data[7];
              state_d = ST_RD;
            end else begin
              oe_d    = 1'b0;
              state_d = (state_q == ST_ACK_ADDR) ? ST_REG : ST_WR;
            end
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (cnt_q == 3'h7) begin
              oe_d    = 1'b0;
              state_d = ST_ACK_RD;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              cnt_d   = cnt_q + 3'h1;
              oe_d    = !shift_q[6];
            end
          end
        end
        ST_ACK_RD: begin
          if (scl_rise && sda_d) begin
            state_d = ST_IDLE;
          end else if (scl_fall) begin
            shift_d = rd_data;
            ptr_d   = ptr_q + 7'h01;
            oe_d    = !rd_data[7];
            cnt_d   = 3'h0;
            state_d = ST_RD;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q   <= 3'h0;
      shift_q <= 8'h00;
      ptr_q   <= 7'h00;
      rw_q    <= 1'b0;
      full_q  <= 1'b0;
      oe_q    <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      ptr_q   <= ptr_d;
      rw_q    <= rw_d;
      full_q  <= full_d;
      oe_q    <= oe_d;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = oe_q;

  // Register write effects
  logic        upd_fire, reg_reset, det_fire, mem_we, ssd_on, run;
  logic [7:0]  ctrl, spread;

  assign ctrl      = mem_q[ADDR_CTRL];
  assign spread    = mem_q[ADDR_SPREAD];
  assign ssd_on    = ctrl[CTRL_SSD_BIT];
  assign upd_fire  = wr_en && ptr_q == ADDR_UPDATE && shift_q == UPDATE_KEY
                     && sdb_q && ssd_on;
  assign reg_reset = wr_en && ptr_q == ADDR_RESET && shift_q == RESET_KEY;
  assign det_fire  = wr_en && ptr_q == ADDR_DETECT
                     && shift_q[DET_EN_BIT];
  assign mem_we    = wr_en && !(ptr_q >= ADDR_STATUS_FIRST
                     && ptr_q <= ADDR_STATUS_LAST);

  always_comb begin
    duty_d   = duty_q;
    status_d = status_q;
    for (int k = 0; k < CHANNELS; k++) begin
      if (upd_fire)
        duty_d[k] = {mem_q[ADDR_DUTY_BASE + 7'(2 * k + 1)],
                     mem_q[ADDR_DUTY_BASE + 7'(2 * k)]};
      if (det_fire)
        status_d[k / 4][2 * (k % 4) + 1] = shift_q[DET_OPEN_BIT] ?
          pin_lvl_q[k] : pin_lvl_q[18 + k];
    end
    if (reg_reset) begin
      duty_d   = '0;
      status_d = '0;
    end
  end

  // Contents survive both shutdowns; only a reset write or reset_n clears them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int a = 0; a < 128; a++)
        mem_q[a] <= REG_RESET_VALUE;
      duty_q   <= '0;
      status_q <= '0;
    end else if (ce) begin
      duty_q   <= duty_d;
      status_q <= status_d;
      if (reg_reset) begin
        for (int a = 0; a < 128; a++)
          mem_q[a] <= REG_RESET_VALUE;
      end else if (mem_we) begin
        mem_q[ptr_q] <= shift_q;
      end
    end
  end

  // Timebase
  pwm_timebase_if tb_if ();

  assign tb_if.osc_sel      = ctrl[CTRL_OSC_LSB +: 3];
  assign tb_if.res_sel      = ctrl[CTRL_RES_LSB +: 2];
  assign tb_if.spread_en    = spread[SPR_EN_BIT];
  assign tb_if.spread_range = spread[SPR_RNG_LSB +: 2];

  pwm_timebase #(
    .SWEEP_CYCLES (SWEEP_CYCLES)
  ) u_timebase (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .tb    (tb_if.timebase)
  );

  // Output drive
  logic [17:0] out_n_q, out_n_d;

  assign run = ssd_on && sdb_q;

  always_comb begin
    for (int k = 0; k < CHANNELS; k++)
      out_n_d[k] = !(run && (!spread[SPR_DC_LSB + k / 6]
                   || tb_if.count < duty_q[k]));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      out_n_q <= '1;
    else if (ce)
      out_n_q <= out_n_d;
  end

  assign led_output_n = out_n_q;

  for (genvar k = 0; k < CHANNELS; k++) begin : g_scale
    assign current_scale[k] = {mem_q[ADDR_SCALE_BASE + 7'(2 * k + 1)],
                               mem_q[ADDR_SCALE_BASE + 7'(2 * k)]};
  end
  assign global_current_level = mem_q[ADDR_GCC];

  // Checks
  soft_blank_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !ssd_on |=> led_output_n == '1)
    else $error("outputs lit in software shutdown");

  hw_blank_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !sdb_q |=> led_output_n == '1)
    else $error("outputs lit in hardware shutdown");

  zero_duty_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && duty_q[0] == 16'h0000 && spread[SPR_DC_LSB] |=> led_output_n[0])
    else $error("zero duty output lit");

  update_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && upd_fire |=> duty_q[0] == {$past(mem_q[2]), $past(mem_q[1])})
    else $error("update did not load pending duty");

  duty_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !upd_fire && !reg_reset |=> $stable(duty_q))
    else $error("active duty changed without update");

  detect_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && det_fire && !reg_reset |=> status_q[0][1] ==
      $past(shift_q[DET_OPEN_BIT] ? pin_lvl_q[0] : pin_lvl_q[18]))
    else $error("fault capture wrong");

  status_ro_a: assert property (@(posedge clk) disable iff (!rst_n)
    !det_fire && !reg_reset |=> $stable(status_q))
    else $error("status changed without detect");

  sdb_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && sdb_rise |=> state_q == ST_IDLE && !sda_oe)
    else $error("serial logic not reset by pin edge");

  regs_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && sdb_rise && !wr_en |=> $stable(mem_q[0]))
    else $error("register lost on shutdown exit");

  update_cov: cover property (@(posedge clk) disable iff (!rst_n)
    ce && upd_fire);
  detect_cov: cover property (@(posedge clk) disable iff (!rst_n)
    ce && det_fire && shift_q[DET_OPEN_BIT]);
  read_cov: cover property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_ACK_RD ##1 state_q == ST_RD);

endmodule

// ---- common/led_pkg.sv ----
// Constants and types shared by the LED PWM controller design
// Summary of operation
// - Eighteen outputs, duty from own register, selectable resolution
// - PWM where spread bits 5-7 enable it per six outputs, else fully on; duty value four gives fourth step
// - Reset resolution 8 bits, about 62kHz period
// - Oscillator and resolution fields set about 1.9Hz to 62kHz
// - All channels share one common PWM counter
// - Detect write 10 captures short, 11 open
// - Fault bits readable, read-only, at 72h to 76h
// - Spread range selects 5, 15, 24, 34 percent
// - Per-output scaling pair at 4Ah to 6Dh
// - Shutdown keeps all register contents
// - Soft shutdown bit cleared enters soft shutdown
// - Soft shutdown blanks outputs, registers stay accessible
// - Shutdown pin low disables outputs until high
// - Shutdown pin rising edge resets serial logic
// - Registers accessible during hardware shutdown
// - Update write of zero loads pending duty values only with shutdown pin high and soft shutdown bit set
// - Detect values 00/01 idle; each enabling write once
package led_pkg;

  localparam int CHANNELS = 18;
  localparam int DUTY_W   = 16;

  // Register offsets
  localparam logic [6:0] ADDR_CTRL         = 7'h00;
  localparam logic [6:0] ADDR_DUTY_BASE    = 7'h01;
  localparam logic [6:0] ADDR_UPDATE       = 7'h49;
  localparam logic [6:0] ADDR_SCALE_BASE   = 7'h4a;
  localparam logic [6:0] ADDR_GCC          = 7'h6e;
  localparam logic [6:0] ADDR_DETECT       = 7'h71;
  localparam logic [6:0] ADDR_STATUS_FIRST = 7'h72;
  localparam logic [6:0] ADDR_STATUS_LAST  = 7'h76;
  localparam logic [6:0] ADDR_SPREAD       = 7'h78;
  localparam logic [6:0] ADDR_RESET        = 7'h7f;

  // Field positions
  localparam int CTRL_SSD_BIT = 0;
  localparam int CTRL_RES_LSB = 1;
  localparam int CTRL_OSC_LSB = 4;
  localparam int DET_EN_BIT   = 1;
  localparam int DET_OPEN_BIT = 0;
  localparam int SPR_RNG_LSB  = 2;
  localparam int SPR_EN_BIT   = 4;
  localparam int SPR_DC_LSB   = 5;

  // Reset values and keys
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam logic [7:0] UPDATE_KEY      = 8'h00;
  localparam logic [7:0] RESET_KEY       = 8'h00;
  localparam logic [38:0] PIN_RESET      = {3'h7, 36'h0};

  // Timing
  localparam int CLK_HZ             = 40_000_000;
  localparam int OSC_HZ             = 16_000_000;
  localparam int SPREAD_HALF_US     = 1980;
  localparam int SPREAD_HALF_CYCLES = SPREAD_HALF_US * (CLK_HZ / 1_000_000);
  localparam logic [8:0] ACC_MOD    = 9'(CLK_HZ / 100_000);
  localparam logic [8:0] ACC_INC    = 9'(OSC_HZ / 100_000);

  // Spread depth in accumulator units, per range code
  localparam logic [3:0][8:0] SPREAD_STEP = {9'h036, 9'h026, 9'h018, 9'h008};

  // Counter mask per resolution code: 8, 10, 12, 16 bits
  localparam logic [3:0][15:0] RES_MASK =
    {16'hffff, 16'h0fff, 16'h03ff, 16'h00ff};

  typedef enum {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_REG, ST_ACK_REG,
    ST_WR, ST_ACK_WR, ST_RD, ST_ACK_RD
  } i2c_state_type;

endpackage

// ---- common/pwm_timebase_if.sv ----
// Shared PWM timebase between controller and counter
`timescale 1ns/1ps
interface pwm_timebase_if;
  logic [2:0]  osc_sel;
  logic [1:0]  res_sel;
  logic        spread_en;
  logic [1:0]  spread_range;
  logic [15:0] count;
  logic        period_start;

  modport timebase (
    input  osc_sel, res_sel, spread_en, spread_range,
    output count, period_start
  );
  modport user (
    output osc_sel, res_sel, spread_en, spread_range,
    input  count, period_start
  );
endinterface

// ---- hw/pwm_timebase.sv ----
// Common PWM counter with oscillator divider and spread spectrum
`timescale 1ns/1ps
module pwm_timebase import led_pkg::*; #(
  parameter int SWEEP_CYCLES = SPREAD_HALF_CYCLES
) (
  // Clock, reset, enable
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  // Timebase
  pwm_timebase_if.timebase   tb
);

  logic [8:0]  acc_q, acc_d;
  logic [7:0]  div_q, div_d;
  logic [15:0] cnt_q, cnt_d;
  logic [16:0] sweep_q, sweep_d;
  logic        sign_q, sign_d;
  logic        start_q, start_d;
  logic [8:0]  inc;
  logic [9:0]  sum;
  logic        osc_tick, div_last, pwm_tick, wrap;
  logic [15:0] mask;

  always_comb begin
    // Spread modulates the emulated oscillator rate
    if (!tb.spread_en)
      inc = ACC_INC;
    else if (sign_q)
      inc = ACC_INC + SPREAD_STEP[tb.spread_range];
    else
      inc = ACC_INC - SPREAD_STEP[tb.spread_range];
    sum      = {1'b0, acc_q} + {1'b0, inc};
    osc_tick = sum >= {1'b0, ACC_MOD};
    acc_d    = osc_tick ? 9'(sum - {1'b0, ACC_MOD}) : sum[8:0];
    sign_d   = sign_q;
    sweep_d  = sweep_q + 17'h00001;
    if (sweep_q >= 17'(SWEEP_CYCLES - 1)) begin
      sweep_d = 17'h00000;
      sign_d  = ~sign_q;
    end
    div_last = div_q >= 8'((1 << tb.osc_sel) - 1);
    pwm_tick = osc_tick && div_last;
    div_d    = div_q;
    if (osc_tick)
      div_d = div_last ? 8'h00 : div_q + 8'h01;
    mask    = RES_MASK[tb.res_sel];
    wrap    = (cnt_q & mask) == mask || (cnt_q & ~mask) != 16'h0000;
    cnt_d   = cnt_q;
    start_d = 1'b0;
    if (pwm_tick) begin
      cnt_d   = wrap ? 16'h0000 : cnt_q + 16'h0001;
      start_d = wrap;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q   <= 9'h000;
      div_q   <= 8'h00;
      cnt_q   <= 16'h0000;
      sweep_q <= 17'h00000;
      sign_q  <= 1'b0;
      start_q <= 1'b0;
    end else if (ce) begin
      acc_q   <= acc_d;
      div_q   <= div_d;
      cnt_q   <= cnt_d;
      sweep_q <= sweep_d;
      sign_q  <= sign_d;
      start_q <= start_d;
    end
  end

  assign tb.count        = cnt_q;
  assign tb.period_start = start_q;

  period_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    tb.period_start |-> tb.count == 16'h0000)
    else $error("period start without counter at zero");

  res_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
    tb.res_sel == 2'b00 && cnt_q <= 16'h00ff |=> cnt_q <= 16'h00ff)
    else $error("8-bit counter left its range");

  wrap_cov: cover property (@(posedge clk) disable iff (!rst_n)
    tb.period_start && tb.res_sel == 2'b00);

endmodule

// ---- bench/i2c_host_model.sv ----
// Host microcontroller model that drives the serial register bus
`timescale 1ns/1ps
module i2c_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h34
) (
  // Clock
  input  wire logic clk,
  // Bus lines
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic host_low;

  // Pull-up: line high unless a party pulls it low
  assign sda = ~(host_low | sda_oe);

  initial begin
    scl      = 1'b1;
    host_low = 1'b0;
  end

  // Change both lines on an edge, then hold well past the pin filter
  task automatic step(input logic c, input logic d);
    @(posedge clk);
    scl      <= c;
    host_low <= ~d;
    repeat (10) @(posedge clk);
  endtask

  // Data moves only while the clock line is low
  task automatic bit_io(input logic b, output logic seen);
    step(1'b0, ~host_low);
    step(1'b0, b);
    step(1'b1, b);
    seen = sda;
  endtask

  task automatic byte_io(input logic [7:0] v, input logic last,
                         output logic [7:0] got, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], got[i]);
    end
    bit_io(last, ack);
  endtask

  task automatic start();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask

  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
                           output logic ok);
    logic [7:0] g;
    logic       k0;
    logic       k1;
    logic       k2;
    start();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, g, k0);
    byte_io(a, 1'b1, g, k1);
    byte_io(d, 1'b1, g, k2);
    stop();
    ok = ~(k0 | k1 | k2);
  endtask

  // Pointer write, repeated start, one byte read and closed by a nack
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic ok);
    logic [7:0] g;
    logic       k0;
    logic       k1;
    logic       k2;
    logic       n;
    start();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, g, k0);
    byte_io(a, 1'b1, g, k1);
    start();
    byte_io({DEV_ADDR, 1'b1}, 1'b1, g, k2);
    byte_io(8'hff, 1'b1, d, n);
    stop();
    ok = ~(k0 | k1 | k2);
  endtask
endmodule

// ---- bench/test_led_channel_pwm_shutdown_ctrl.sv ----
// Self-checking bench for the LED PWM and shutdown controller
`timescale 1ns/1ps
module test_led_channel_pwm_shutdown_ctrl import led_pkg::*; ();
  localparam logic [6:0] DEV = 7'h34; // arbitrary value

  logic              clk;
  logic              reset_n;
  logic              hw_shutdown_n_pin;
  logic [17:0]       short_sense;
  logic [17:0]       open_sense;
  logic              scl;
  logic              sda;
  logic              sda_oe;
  logic              sda_out;
  logic              ce;
  logic [17:0]       led_output_n;
  logic [17:0][15:0] current_scale;
  logic [7:0]        global_current_level;
  logic              ok;
  logic [7:0]        rd;
  int                n_mismatch;
  int                compares;

  led_channel_pwm_shutdown_ctrl #(.DEV_ADDR(DEV), .SWEEP_CYCLES(64)) dut (
    .clk                  (clk),
    .reset_n              (reset_n),
    .ce                   (ce),
    .scl_in               (scl),
    .sda_in               (sda),
    .sda_out              (sda_out),
    .sda_oe               (sda_oe),
    .hw_shutdown_n_pin    (hw_shutdown_n_pin),
    .short_sense          (short_sense),
    .open_sense           (open_sense),
    .led_output_n         (led_output_n),
    .current_scale        (current_scale),
    .global_current_level (global_current_level)
  );

  i2c_host_model #(.DEV_ADDR(DEV)) host (
    .clk    (clk),
    .sda_oe (sda_oe),
    .scl    (scl),
    .sda    (sda)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write_reg(a, d, ok);
    check("write ack", ok, 1'b1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host.read_reg(a, rd, ok);
    check("read ack", ok, 1'b1);
    check("read data", rd, exp);
  endtask

  // Low cycles of one channel, and cycles where it differs from channel 2
  task automatic lows(input int n, input int ch, output int cnt,
                      output int diff);
    cnt = 0;
    diff = 0;
    repeat (n) begin
      @(negedge clk);
      cnt += int'(led_output_n[ch] === 1'b0);
      diff += int'(led_output_n[ch] !== led_output_n[2]);
    end
  endtask

  // Status byte i: channel 4i+j at bit 2j+1
  function automatic logic [7:0] stat(input logic [17:0] v, input int i);
    logic [7:0] b;
    b = 8'h00;
    for (int j = 0; j < 4; j++) begin
      if (4 * i + j < 18) b[2 * j + 1] = v[4 * i + j];
    end
    return b;
  endfunction

  task automatic results();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (99000) @(posedge clk);
    n_mismatch++;
    results();
  end

  initial begin
    int         c;
    int         d;
    logic [1:0] r;
    logic [2:0] o;
    logic [7:0] av;
    n_mismatch = 0;
    compares = 0;
    reset_n = 1'b0;
    ce = 1'b1;
    hw_shutdown_n_pin = 1'b1;
    short_sense = 18'h0;
    open_sense = 18'h0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    check("sda_oe", sda_oe, 1'b0);
    check("sda_out", sda_out, 1'b0);
    check("outputs at reset", led_output_n, 18'h3ffff);
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h78, 8'h00);
    // Scaling and global current reach the output stage at once
    wr(8'h4a, 8'h80);
    wr(8'h4b, 8'hc3);
    wr(8'h6d, 8'h5a);
    check("scale 0", current_scale[0], 16'hc380);
    check("scale 17", current_scale[17], 16'h5a00);
    wr(8'h6e, 8'h01);
    check("global current", global_current_level, 8'h01);
    // Duty writes stay pending until the update write
    wr(8'h00, 8'h01);
    wr(8'h78, 8'he0);
    wr(8'h01, 8'h04);
    wr(8'h05, 8'h04);
    lows(640, 0, c, d);
    check("pending duty", c, 0);
    wr(8'h49, 8'h00);
    rd_chk(8'h49, 8'h00);
    // Resolution and divider table; one settling period before measuring
    for (int m = 0; m < 4; m++) begin
      r = (m == 3) ? 2'd0 : m[1:0];
      o = (m == 3) ? 3'd1 : 3'd0;
      wr(8'h00, {1'b0, o, 1'b0, r, 1'b1});
      repeat (640 << (2 * r + o)) @(posedge clk);
      lows(640 << (2 * r + o), 0, c, d);
      check("on time", c, 10 << o);
      check("common timebase", d, 0);
    end
    wr(8'h00, 8'h01);
    lows(640, 1, c, d);
    check("zero duty", c, 0);
    // Clock enable low freezes the outputs: all on or all off
    @(posedge clk);
    ce <= 1'b0;
    lows(640, 0, c, d);
    @(posedge clk);
    ce <= 1'b1;
    check("frozen output", c % 640, 0);
    // Soft shutdown blanks outputs and keeps contents
    wr(8'h00, 8'h00);
    lows(640, 0, c, d);
    check("soft off", c, 0);
    rd_chk(8'h01, 8'h04);
    wr(8'h00, 8'h01);
    // Hardware shutdown; update refused while the pin is low
    @(posedge clk);
    hw_shutdown_n_pin <= 1'b0;
    // Pin filter and output register latency before measuring
    repeat (8) @(posedge clk);
    lows(640, 0, c, d);
    check("hw off", c, 0);
    wr(8'h6e, 8'h05);
    rd_chk(8'h6e, 8'h05);
    wr(8'h01, 8'h08);
    wr(8'h49, 8'h00);
    hw_shutdown_n_pin <= 1'b1;
    repeat (640) @(posedge clk);
    lows(640, 0, c, d);
    check("hw on", c, 10);
    // Pin rising edge drops an acknowledge in progress
    av = {DEV, 1'b0};
    host.start();
    for (int i = 7; i >= 0; i--) begin
      host.bit_io(av[i], ok);
    end
    host.step(1'b0, 1'b1);
    check("ack driven", sda_oe, 1'b1);
    hw_shutdown_n_pin <= 1'b0;
    repeat (10) @(posedge clk);
    hw_shutdown_n_pin <= 1'b1;
    repeat (10) @(posedge clk);
    check("serial reset", sda_oe, 1'b0);
    host.stop();
    rd_chk(8'h6e, 8'h05);
    // Fault capture: short, then open, idle codes change nothing
    short_sense <= 18'h2a5c3;
    open_sense <= 18'h15a3c;
    wr(8'h6e, 8'h01);
    wr(8'h71, 8'h02);
    for (int i = 0; i < 5; i++) begin
      rd_chk(8'h72 + i[7:0], stat(18'h2a5c3, i));
    end
    wr(8'h71, 8'h03);
    wr(8'h72, 8'hff);
    short_sense <= 18'h0;
    open_sense <= 18'h3ffff;
    wr(8'h71, 8'h01);
    wr(8'h71, 8'h00);
    for (int i = 0; i < 5; i++) begin
      rd_chk(8'h72 + i[7:0], stat(18'h15a3c, i));
    end
    // Every spread range code with spreading on
    for (int i = 0; i < 4; i++) begin
      wr(8'h78, {4'hf, i[1:0], 2'b00});
      rd_chk(8'h78, {4'hf, i[1:0], 2'b00});
    end
    wr(8'h7f, 8'h00);
    rd_chk(8'h6e, 8'h00);
    check("scale cleared", current_scale[0], 16'h0000);
    results();
  end
endmodule
